/* File: src/acrf_top.v */
// Converter configuration, successive-approximation sequencer and result byte formatting
`timescale 1ns/1ps
`include "acrf_map.vh"

module acrf_top (
	input  wire       I_CLK_SYS,
	input  wire       I_RESETN,
	input  wire [7:0] I_SFR_ADDR,
	input  wire       I_SFR_WR,
	input  wire       I_SFR_RD,
	input  wire [7:0] I_SFR_WDATA,
	input  wire       I_CONV_START,
	input  wire       I_CMP_ABOVE,
	output reg  [7:0] O_SFR_RDATA,
	output reg  [9:0] O_SAR_TRIAL,
	output reg        O_SAR_CLK_TICK,
	output reg        O_GAIN_UNITY,
	output reg        O_EIGHT_BIT,
	output reg        O_BUSY,
	output reg        O_CONV_DONE
);

	// ************************************************************************
	// State
	// ************************************************************************
	localparam ST_IDLE = 2'b01;
	localparam ST_CONV = 2'b10;

	reg  [1:0] state;
	reg  [1:0] next_state;
	reg  [7:0] converter_config_reg;
	reg  [7:0] result_low_byte;
	reg  [7:0] result_high_byte;
	reg  [4:0] div_cnt;
	reg  [3:0] bit_idx;
	reg  [9:0] trial;
	reg        cmp_meta;
	reg        cmp_sync;
	reg  [7:0] next_low;
	reg  [7:0] next_high;
	reg  [9:0] resolved;

	wire [4:0] sar_clock_divider;
	wire       left_align_select;
	wire       eight_bit_mode_enable;
	wire       gain_select;
	wire       sar_tick;
	wire [3:0] stop_idx;
	wire       last_bit;
	wire       finish;
	wire       start;
	wire [9:0] bit_mask;

	assign sar_clock_divider     = converter_config_reg[`ACRF_CFG_DIV_HI:`ACRF_CFG_DIV_LO];
	assign left_align_select     = converter_config_reg[`ACRF_CFG_LEFT_ALIGN];
	assign eight_bit_mode_enable = converter_config_reg[`ACRF_CFG_EIGHT_BIT];
	assign gain_select           = converter_config_reg[`ACRF_CFG_GAIN];

	// ************************************************************************
	// Comparator synchroniser
	// ************************************************************************
	// The comparator must settle within one conversion clock; below divider 3
	// the trial output register and the two-flop delay leave no time, hence the advice to keep it at 3 or more.
	always @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_meta <= I_CMP_ABOVE;
			cmp_sync <= cmp_meta;
		end
	end

	// ************************************************************************
	// Conversion clock divider
	// ************************************************************************
	assign sar_tick = (state == ST_CONV) && (div_cnt == sar_clock_divider);
	assign start    = (state == ST_IDLE) && I_CONV_START;

	always @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			div_cnt <= `ACRF_DIV_ZERO;
		end else if (start || sar_tick) begin
			div_cnt <= `ACRF_DIV_ZERO;
		end else if (state == ST_CONV) begin
			div_cnt <= div_cnt + `ACRF_DIV_ONE;
		end
	end

	// ************************************************************************
	// Successive approximation
	// ************************************************************************
	assign stop_idx = eight_bit_mode_enable ? `ACRF_BIT_STOP_8 : `ACRF_BIT_STOP_10;
	assign last_bit = (bit_idx == stop_idx);
	assign finish   = sar_tick && last_bit;
	assign bit_mask = `ACRF_CODE_ONE << bit_idx;

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (I_CONV_START) begin
					next_state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (finish) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Trial bit is kept when the input is above the trial level, else cleared
	always @* begin
		resolved = cmp_sync ? trial : (trial & ~bit_mask);
	end

	always @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state   <= ST_IDLE;
			bit_idx <= `ACRF_BIT_TOP;
			trial   <= `ACRF_CODE_ZERO;
		end else begin
			state <= next_state;
			if (start) begin
				bit_idx <= `ACRF_BIT_TOP;
				trial   <= `ACRF_CODE_ONE << `ACRF_BIT_TOP;
			end else if (sar_tick && !last_bit) begin
				bit_idx <= bit_idx - `ACRF_BIT_STEP;
				trial   <= resolved | (bit_mask >> 1);
			end else if (finish) begin
				trial <= resolved;
			end
		end
	end

	// ************************************************************************
	// Result formatting
	// ************************************************************************
	always @* begin
		if (eight_bit_mode_enable) begin
			next_high = resolved[9:2];
			next_low  = `ACRF_BYTE_ZERO;
		end else if (left_align_select) begin
			next_high = resolved[9:2];
			next_low  = {resolved[1:0], `ACRF_PAD6};
		end else begin
			next_high = {`ACRF_PAD6, resolved[9:8]};
			next_low  = resolved[7:0];
		end
	end

	// ************************************************************************
	// Register file
	// ************************************************************************
	// A completing conversion wins over a software write to a result byte in
	// the same cycle, so no result is lost.
	always @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			converter_config_reg <= `ACRF_RST_CONFIG;
			result_low_byte      <= `ACRF_RST_RESULT;
			result_high_byte     <= `ACRF_RST_RESULT;
		end else begin
			if (I_SFR_WR && I_SFR_ADDR == `ACRF_ADDR_CONFIG) begin
				converter_config_reg <= I_SFR_WDATA;
			end
			if (finish) begin
				result_low_byte  <= next_low;
				result_high_byte <= next_high;
			end else begin
				if (I_SFR_WR && I_SFR_ADDR == `ACRF_ADDR_RES_LOW) begin
					result_low_byte <= I_SFR_WDATA;
				end
				if (I_SFR_WR && I_SFR_ADDR == `ACRF_ADDR_RES_HIGH) begin
					result_high_byte <= I_SFR_WDATA;
				end
			end
		end
	end

	// ************************************************************************
	// Read port and status outputs
	// ************************************************************************
	always @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_SFR_RDATA    <= `ACRF_RST_READ;
			O_SAR_TRIAL    <= `ACRF_CODE_ZERO;
			O_SAR_CLK_TICK <= 1'b0;
			O_GAIN_UNITY   <= 1'b1;
			O_EIGHT_BIT    <= 1'b0;
			O_BUSY         <= 1'b0;
			O_CONV_DONE    <= 1'b0;
		end else begin
			if (I_SFR_RD) begin
				case (I_SFR_ADDR)
					`ACRF_ADDR_CONFIG:   O_SFR_RDATA <= converter_config_reg;
					`ACRF_ADDR_RES_LOW:  O_SFR_RDATA <= result_low_byte;
					`ACRF_ADDR_RES_HIGH: O_SFR_RDATA <= result_high_byte;
					default:             O_SFR_RDATA <= `ACRF_RST_READ;
				endcase
			end
			O_SAR_TRIAL    <= trial;
			O_SAR_CLK_TICK <= sar_tick;
			O_GAIN_UNITY   <= gain_select;
			O_EIGHT_BIT    <= eight_bit_mode_enable;
			O_BUSY         <= (next_state == ST_CONV);
			O_CONV_DONE    <= finish;
		end
	end

endmodule // acrf_top

/* File: src/acrf_map.vh */
// Register map, field positions, reset values and counts of the converter block
// ****************************************************************************
// ****************************************************************************
`ifndef ACRF_MAP_VH
`define ACRF_MAP_VH

// ****************************************************************************
// Register addresses
// ****************************************************************************
`define ACRF_ADDR_CONFIG      8'hbc
`define ACRF_ADDR_RES_LOW     8'hbd
`define ACRF_ADDR_RES_HIGH    8'hbe

// ****************************************************************************
// Reset values
// ****************************************************************************
`define ACRF_RST_CONFIG       8'hf9
`define ACRF_RST_RESULT       8'h00
`define ACRF_RST_READ         8'h00

// ****************************************************************************
// Configuration fields
// ****************************************************************************
`define ACRF_CFG_DIV_HI       7
`define ACRF_CFG_DIV_LO       3
`define ACRF_CFG_LEFT_ALIGN   2
`define ACRF_CFG_EIGHT_BIT    1
`define ACRF_CFG_GAIN         0

// ****************************************************************************
// Conversion counts and codes
// ****************************************************************************
`define ACRF_DIV_ZERO         5'h00
`define ACRF_DIV_ONE          5'h01
`define ACRF_BIT_TOP          4'h9
`define ACRF_BIT_STOP_10      4'h0
`define ACRF_BIT_STOP_8       4'h2
`define ACRF_BIT_STEP         4'h1
`define ACRF_CODE_ZERO        10'h000
`define ACRF_CODE_ONE         10'h001
`define ACRF_PAD6             6'h00
`define ACRF_BYTE_ZERO        8'h00

`endif

/* File: verification/acrf_properties.sv */
// Port-level assertions for the converter block
`timescale 1ns/1ps
module acrf_chk (
	input wire       I_CLK_SYS,
	input wire       I_RESETN,
	input wire [7:0] I_SFR_ADDR,
	input wire       I_SFR_WR,
	input wire       I_SFR_RD,
	input wire [7:0] I_SFR_WDATA,
	input wire       I_CONV_START,
	input wire       I_CMP_ABOVE,
	input wire [7:0] O_SFR_RDATA,
	input wire [9:0] O_SAR_TRIAL,
	input wire       O_SAR_CLK_TICK,
	input wire       O_GAIN_UNITY,
	input wire       O_EIGHT_BIT,
	input wire       O_BUSY,
	input wire       O_CONV_DONE
);
	// Shadow config; a divider change mid-conversion would upset the tick checks
	// The final tick and the done pulse share a cycle, so the count there is one short
	logic [7:0] cfg;
	logic [4:0] gap;
	logic [3:0] nt;
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESETN);
	always @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			cfg <= 8'hf9;
			gap <= 5'h00;
			nt  <= 4'h0;
		end else begin
			if (I_SFR_WR && I_SFR_ADDR == 8'hbc) cfg <= I_SFR_WDATA;
			gap <= O_SAR_CLK_TICK ? 5'h00 : gap + 5'h01;
			nt  <= O_CONV_DONE ? 4'h0 : nt + {3'h0, O_SAR_CLK_TICK};
		end
	end
	property p_div; O_SAR_CLK_TICK && nt != 0 |-> gap == cfg[7:3]; endproperty
	a_div: assert property (p_div) else $error("tick spacing");
	property p_cnt; O_CONV_DONE |-> nt == (cfg[1] ? 4'h7 : 4'h9); endproperty
	a_cnt: assert property (p_cnt) else $error("tick count");
	property p_gain; I_SFR_WR && I_SFR_ADDR == 8'hbc |-> ##2 O_GAIN_UNITY == cfg[0]; endproperty
	a_gain: assert property (p_gain) else $error("gain output");
	property p_eight; I_SFR_WR && I_SFR_ADDR == 8'hbc |-> ##2 O_EIGHT_BIT == cfg[1]; endproperty
	a_eight: assert property (p_eight) else $error("width output");
	property p_cfg; I_SFR_RD && I_SFR_ADDR == 8'hbc |=> O_SFR_RDATA == $past(cfg); endproperty
	a_cfg: assert property (p_cfg) else $error("config readback");
	property p_lsb; O_SAR_CLK_TICK && O_EIGHT_BIT && nt != 0 |-> O_SAR_TRIAL[1:0] == 2'h0; endproperty
	a_lsb: assert property (p_lsb) else $error("low trial bits");
	property p_fell; $fell(O_BUSY) |-> O_CONV_DONE; endproperty
	a_fell: assert property (p_fell) else $error("busy end");
	property p_start; I_CONV_START && !O_BUSY |=> O_BUSY; endproperty
	a_start: assert property (p_start) else $error("start");
	c_eight: cover property (O_CONV_DONE && cfg[1]);
	c_left: cover property (O_CONV_DONE && !cfg[1] && cfg[2]);
	c_rd: cover property (I_SFR_RD && I_SFR_ADDR == 8'hbe);
endmodule // acrf_chk
bind acrf_top acrf_chk u_chk (.*);

/* File: verification/tb_top.sv */
// Self-checking bench for the converter configuration and result bytes
`timescale 1ns/1ps
module tb_top;
	logic        I_CLK_SYS = 0, I_RESETN = 0, I_SFR_WR = 0, I_SFR_RD = 0, rd_q = 0;
	logic        I_CONV_START = 0, I_CMP_ABOVE = 0;
	logic [7:0]  I_SFR_ADDR = 0, I_SFR_WDATA = 0, c, expq[$];
	logic [9:0]  tgt = 0;
	logic [15:0] e;
	wire  [7:0]  O_SFR_RDATA;
	wire  [9:0]  O_SAR_TRIAL;
	wire         O_SAR_CLK_TICK, O_GAIN_UNITY, O_EIGHT_BIT, O_BUSY, O_CONV_DONE;
	int          n_fail = 0, comparisons = 0, k, i;
	always #4 I_CLK_SYS = ~I_CLK_SYS;
	acrf_top DUT (.*);
	// Fixed input level; a divider of 3 or more lets the synchroniser settle
	always @(negedge I_CLK_SYS) I_CMP_ABOVE <= (O_SAR_TRIAL <= tgt);
	always @(posedge I_CLK_SYS) begin
		if (rd_q) chk(expq.pop_front(), O_SFR_RDATA);
		rd_q <= I_SFR_RD;
	end
	task chk(input logic [7:0] x, input logic [7:0] g);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, g, x);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge I_CLK_SYS);
		I_SFR_ADDR = a;
		I_SFR_WDATA = d;
		I_SFR_WR = w;
		I_SFR_RD = !w;
		if (!w) expq.push_back(d);
		@(negedge I_CLK_SYS);
		I_SFR_WR = 0;
		I_SFR_RD = 0;
	endtask
	task close_out();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		k = $urandom(32'hb70f_6b7c);
		repeat (12) @(negedge I_CLK_SYS);
		I_RESETN = 1;
		acc(0, 8'hbc, 8'hf9);
		acc(0, 8'hbd, 8'h00);
		acc(0, 8'hbe, 8'h00);
		acc(0, 8'hbf, 8'h00);
		for (k = 0; k < 16; k++) begin
			c = {5'($urandom_range(7, 3)), k[2:0]};
			tgt = (k < 2) ? {10{k[0]}} : 10'($urandom_range(1023));
			e = c[1] ? {tgt[9:2], 8'h00} : c[2] ? {tgt, 6'h00} : {6'h00, tgt};
			acc(1, 8'hbc, c);
			// Stale bytes prove that completion rewrites both
			acc(1, 8'hbd, 8'ha5);
			acc(1, 8'hbe, 8'ha5);
			@(negedge I_CLK_SYS);
			I_CONV_START = 1;
			@(negedge I_CLK_SYS);
			I_CONV_START = 0;
			for (i = 0; i < 400 && O_CONV_DONE !== 1'b1; i++) @(negedge I_CLK_SYS);
			chk(8'h01, {7'h00, O_CONV_DONE});
			if (O_CONV_DONE !== 1'b1) close_out();
			acc(0, 8'hbc, c);
			acc(0, 8'hbd, e[7:0]);
			acc(0, 8'hbe, e[15:8]);
		end
		repeat (2) @(posedge I_CLK_SYS);
		close_out();
	end
endmodule // tb_top
